// File: common/psl_pkg.sv
// constants and lookup functions of the power sequencing block
// Operation
// - input overvoltage always latches off switching
// - overvoltage sets input status flag bit
// - select bit picks 16.5 V or 18.5 V
// - overvoltage clears below fixed 13.5 V
// - no alert output; status read only
// - unused setting bits always read zero
// - turn-on wait 0.5/1/1.5/2 ms before switching
// - soft-start ramp 1/2/4/8/16 ms
// - exact rise time only under processor control
// - turn-off wait 0/1/1.5/2 ms before soft-stop
// - soft-stop disabled: tri-state at once
// - soft-stop ramp 0.5/1/2/4 ms to zero
// - stop switching once output reaches 200 mV
// - settings load from nvm, apply immediately
// - soft-start setting may come from strap
// - status flag clears by flush or write-one
package psl_pkg;
  // command codes
  localparam logic [7:0] PSL_CMD_OV_LIMIT = 8'h55;
  localparam logic [7:0] PSL_CMD_TON_WAIT = 8'h60;
  localparam logic [7:0] PSL_CMD_RISE = 8'h61;
  localparam logic [7:0] PSL_CMD_TOFF_WAIT = 8'h64;
  localparam logic [7:0] PSL_CMD_FALL = 8'h65;
  localparam logic [7:0] PSL_CMD_STATUS_IN = 8'h7c;
  localparam logic [7:0] PSL_CMD_SETUP1 = 8'ha0;
  localparam logic [7:0] PSL_CMD_FLUSH = 8'h03;
  // field positions
  localparam int PSL_OV_FLAG_BIT = 7;
  localparam int PSL_SOFT_STOP_BIT = 0;
  localparam logic [7:0] PSL_READ_ZERO = 8'h00;
  // thresholds in millivolts
  localparam logic [15:0] PSL_OV_RISE_LO_MV = 16'd16500;
  localparam logic [15:0] PSL_OV_RISE_HI_MV = 16'd18500;
  localparam logic [15:0] PSL_OV_FALL_MV = 16'd13500;
  localparam logic [11:0] PSL_DISCHARGED_MV = 12'd200;
  // clock rate; cycle counts derive from it
  localparam int PSL_CLK_MHZ = 200;
  localparam logic [3:0] PSL_I2C_BITS = 4'd8;

  // turn-on wait in microseconds
  function automatic int psl_ton_us(input logic [1:0] sel);
    unique case (sel)
      2'b00: psl_ton_us = 500;
      2'b01: psl_ton_us = 1000;
      2'b10: psl_ton_us = 1500;
      default: psl_ton_us = 2000;
    endcase
  endfunction : psl_ton_us

  // soft-start ramp in microseconds; upper codes saturate
  function automatic int psl_rise_us(input logic [2:0] sel);
    unique case (sel)
      3'b000: psl_rise_us = 1000;
      3'b001: psl_rise_us = 2000;
      3'b010: psl_rise_us = 4000;
      3'b011: psl_rise_us = 8000;
      default: psl_rise_us = 16000;
    endcase
  endfunction : psl_rise_us

  // turn-off wait in microseconds
  function automatic int psl_toff_us(input logic [1:0] sel);
    unique case (sel)
      2'b00: psl_toff_us = 0;
      2'b01: psl_toff_us = 1000;
      2'b10: psl_toff_us = 1500;
      default: psl_toff_us = 2000;
    endcase
  endfunction : psl_toff_us

  // soft-stop ramp in microseconds
  function automatic int psl_fall_us(input logic [1:0] sel);
    unique case (sel)
      2'b00: psl_fall_us = 500;
      2'b01: psl_fall_us = 1000;
      2'b10: psl_fall_us = 2000;
      default: psl_fall_us = 4000;
    endcase
  endfunction : psl_fall_us
endpackage : psl_pkg

// File: design/psl_ramp.sv
// linear reference ramp generator, error-accumulating stepper
`timescale 1ns/1ps
`default_nettype none
module psl_ramp (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic down_i,
  input wire logic abort_i,
  input wire logic [11:0] target_i,
  input wire logic [11:0] span_i,
  input wire logic [31:0] total_i,
  output logic [11:0] ref_o,
  output logic done_o
);
  typedef struct packed {
    logic active;
    logic down;
    logic [11:0] level;
    logic [11:0] limit;
    logic [11:0] span;
    logic [31:0] acc;
  } psl_ramp_t;

  psl_ramp_t s;
  psl_ramp_t next_s;
  logic reached;
  logic [32:0] sum;

  assign reached = s.down ? (s.level == 12'h000) : (s.level >= s.limit);

  // one millivolt step whenever the accumulated span passes the total
  always_comb begin
    next_s = s;
    sum = {1'b0, s.acc} + {21'h0, s.span};
    if (abort_i) begin
      next_s.active = 1'b0;
      next_s.level = 12'h000;
    end else if (start_i) begin
      next_s.active = 1'b1;
      next_s.down = down_i;
      next_s.acc = 32'h0;
      next_s.limit = target_i;
      next_s.span = down_i ? s.level : span_i;
      if (!down_i) begin
        next_s.level = 12'h000;
      end
    end else if (s.active) begin
      if (reached) begin
        next_s.active = 1'b0;
      end else if (sum >= {1'b0, total_i}) begin
        // total read live so a rewritten time applies mid-ramp
        next_s.acc = 32'(sum - {1'b0, total_i});
        next_s.level = s.down ? s.level - 12'h001 : s.level + 12'h001;
      end else begin
        next_s.acc = sum[31:0];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign ref_o = s.level;
  assign done_o = s.active & reached;
endmodule : psl_ramp
`default_nettype wire

// File: design/psl_seq.sv
// power sequencing core: i2c slave, settings, overvoltage, sequencer
`timescale 1ns/1ps
`default_nettype none
module psl_seq
  import psl_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = 7'h24, // arbitrary bus address
  parameter int CYC_PER_US = PSL_CLK_MHZ,
  parameter logic [11:0] BOOT_SPAN_MV = 12'd1000
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic run_request_i,
  input wire logic [15:0] power_input_voltage_i,
  input wire logic [11:0] vout_sense_mv_i,
  input wire logic [11:0] vout_target_mv_i,
  input wire logic vid_control_i,
  input wire logic input_ov_select_nvm_i,
  input wire logic [1:0] ton_wait_nvm_i,
  input wire logic [2:0] rise_nvm_i,
  input wire logic [2:0] rise_strap_i,
  input wire logic rise_from_strap_i,
  input wire logic [1:0] toff_wait_nvm_i,
  input wire logic [1:0] fall_nvm_i,
  input wire logic soft_stop_en_nvm_i,
  output logic switch_enable_o,
  output logic [11:0] reference_mv_o
);
  typedef enum logic [6:0] {
    PSL_I_IDLE = 7'h01,
    PSL_I_ADDR = 7'h02,
    PSL_I_CMD = 7'h04,
    PSL_I_WDATA = 7'h08,
    PSL_I_ACK = 7'h10,
    PSL_I_RDATA = 7'h20,
    PSL_I_MACK = 7'h40
  } psl_i2c_t;

  typedef enum logic [6:0] {
    PSL_S_OFF = 7'h01,
    PSL_S_TON = 7'h02,
    PSL_S_RISE = 7'h04,
    PSL_S_ON = 7'h08,
    PSL_S_TOFF = 7'h10,
    PSL_S_FALL = 7'h20,
    PSL_S_FAULT = 7'h40
  } psl_seq_t;

  typedef struct packed {
    logic scl_d;
    logic sda_d;
    psl_i2c_t istate;
    psl_i2c_t after_ack;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] cmd;
    logic sda_drive;
    logic loaded;
    logic input_ov_select;
    logic [1:0] ton_sel;
    logic [2:0] rise_sel;
    logic [1:0] toff_sel;
    logic [1:0] fall_sel;
    logic soft_stop_en;
    logic ov_active;
    logic ov_flag;
    psl_seq_t seq;
    logic [31:0] timer;
    logic sw_en;
  } psl_state_t;

  psl_state_t s;
  psl_state_t next_s;
  logic [2:0] pins_sync;
  logic scl;
  logic sda;
  logic run;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic flag_clear;
  logic [7:0] rd_val;
  logic ramp_start;
  logic ramp_down;
  logic ramp_abort;
  logic ramp_done;
  logic [11:0] ramp_ref;
  logic [11:0] ramp_span;
  logic [31:0] ramp_total;
  logic [31:0] ton_cyc;
  logic [31:0] toff_cyc;
  logic [15:0] rise_thr;

  // converts a time in microseconds to clock cycles
  function automatic logic [31:0] to_cycles(input int us);
    to_cycles = 32'(us * CYC_PER_US);
  endfunction : to_cycles

  // pins and the run request come from outside the clock domain
  psl_sync #(
    .W(3)
  ) u_sync (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .async_i({run_request_i, sda_i, scl_i}),
    .sync_o(pins_sync)
  );

  psl_ramp u_ramp (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .start_i(ramp_start),
    .down_i(ramp_down),
    .abort_i(ramp_abort),
    .target_i(vout_target_mv_i),
    .span_i(ramp_span),
    .total_i(ramp_total),
    .ref_o(ramp_ref),
    .done_o(ramp_done)
  );

  assign scl = pins_sync[0];
  assign sda = pins_sync[1];
  assign run = pins_sync[2];
  assign scl_rise = scl & ~s.scl_d;
  assign scl_fall = ~scl & s.scl_d;
  assign bus_start = scl & s.scl_d & s.sda_d & ~sda;
  assign bus_stop = scl & s.scl_d & ~s.sda_d & sda;

  // live cycle counts so a rewritten setting applies at once
  // immediate effect
  assign ton_cyc = to_cycles(psl_ton_us(s.ton_sel));
  assign toff_cyc = s.soft_stop_en ? to_cycles(psl_toff_us(s.toff_sel)) : 32'h0;
  assign rise_thr = s.input_ov_select ? PSL_OV_RISE_HI_MV : PSL_OV_RISE_LO_MV;

  // read mux; reserved bits stay zero
  // upper bits zero
  always_comb begin
    rd_val = PSL_READ_ZERO;
    unique case (s.cmd)
      PSL_CMD_OV_LIMIT: rd_val = {7'h00, s.input_ov_select};
      PSL_CMD_TON_WAIT: rd_val = {6'h00, s.ton_sel};
      PSL_CMD_RISE: rd_val = {5'h00, s.rise_sel};
      PSL_CMD_TOFF_WAIT: rd_val = {6'h00, s.toff_sel};
      PSL_CMD_FALL: rd_val = {6'h00, s.fall_sel};
      PSL_CMD_STATUS_IN: rd_val[PSL_OV_FLAG_BIT] = s.ov_flag;
      PSL_CMD_SETUP1: rd_val[PSL_SOFT_STOP_BIT] = s.soft_stop_en;
      default: rd_val = PSL_READ_ZERO;
    endcase
  end

  // host-set boot uses a fixed span, so its time varies
  // exact time only under processor control
  always_comb begin
    ramp_span = vid_control_i ? vout_target_mv_i : BOOT_SPAN_MV;
    ramp_total = to_cycles(psl_rise_us(s.rise_sel));
    if (s.seq == PSL_S_FALL || s.seq == PSL_S_TOFF || ramp_down) begin
      ramp_total = to_cycles(psl_fall_us(s.fall_sel));
    end
  end

  always_comb begin
    next_s = s;
    flag_clear = 1'b0;
    ramp_start = 1'b0;
    ramp_down = 1'b0;
    ramp_abort = 1'b0;
    next_s.scl_d = scl;
    next_s.sda_d = sda;

    // settings load once, first cycle after reset
    // nvm initial values
    if (!s.loaded) begin
      next_s.loaded = 1'b1;
      next_s.input_ov_select = input_ov_select_nvm_i;
      next_s.ton_sel = ton_wait_nvm_i;
      next_s.rise_sel = rise_from_strap_i ? rise_strap_i : rise_nvm_i;
      next_s.toff_sel = toff_wait_nvm_i;
      next_s.fall_sel = fall_nvm_i;
      next_s.soft_stop_en = soft_stop_en_nvm_i;
    end

    // i2c byte-command slave; a stop or start aborts any byte in flight
    // single-byte write and read by command code
    if (bus_stop) begin
      next_s.istate = PSL_I_IDLE;
      next_s.sda_drive = 1'b0;
    end else if (bus_start) begin
      next_s.istate = PSL_I_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.sda_drive = 1'b0;
    end else begin
      unique case (s.istate)
        PSL_I_IDLE: begin
          next_s.sda_drive = 1'b0;
        end
        PSL_I_ADDR, PSL_I_CMD, PSL_I_WDATA: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], sda};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall && s.bitcnt == PSL_I2C_BITS) begin
            next_s.bitcnt = 4'h0;
            next_s.sda_drive = 1'b1;
            next_s.istate = PSL_I_ACK;
            if (s.istate == PSL_I_ADDR) begin
              // foreign address: stay silent until the next start
              if (s.shreg[7:1] != I2C_ADDR) begin
                next_s.sda_drive = 1'b0;
                next_s.istate = PSL_I_IDLE;
              end
              next_s.after_ack = s.shreg[0] ? PSL_I_RDATA : PSL_I_CMD;
            end else if (s.istate == PSL_I_CMD) begin
              next_s.cmd = s.shreg;
              next_s.after_ack = PSL_I_WDATA;
              flag_clear = (s.shreg == PSL_CMD_FLUSH);
            end else begin
              next_s.after_ack = PSL_I_WDATA;
              // writes keep only the defined field bits
              unique case (s.cmd)
                PSL_CMD_OV_LIMIT: next_s.input_ov_select = s.shreg[0];
                PSL_CMD_TON_WAIT: next_s.ton_sel = s.shreg[1:0];
                PSL_CMD_RISE: next_s.rise_sel = s.shreg[2:0];
                PSL_CMD_TOFF_WAIT: next_s.toff_sel = s.shreg[1:0];
                PSL_CMD_FALL: next_s.fall_sel = s.shreg[1:0];
                PSL_CMD_STATUS_IN: flag_clear = s.shreg[PSL_OV_FLAG_BIT];
                PSL_CMD_SETUP1: next_s.soft_stop_en = s.shreg[PSL_SOFT_STOP_BIT];
                default: flag_clear = 1'b0;
              endcase
            end
          end
        end
        PSL_I_ACK: begin
          if (scl_fall) begin
            next_s.istate = s.after_ack;
            next_s.sda_drive = 1'b0;
            if (s.after_ack == PSL_I_RDATA) begin
              // load the byte and present its msb right away
              next_s.shreg = rd_val;
              next_s.sda_drive = ~rd_val[7];
              next_s.bitcnt = 4'h1;
            end
          end
        end
        PSL_I_RDATA: begin
          if (scl_fall) begin
            if (s.bitcnt == PSL_I2C_BITS) begin
              next_s.sda_drive = 1'b0;
              next_s.istate = PSL_I_MACK;
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.sda_drive = ~s.shreg[6];
              next_s.bitcnt = s.bitcnt + 4'h1;
            end
          end
        end
        PSL_I_MACK: begin
          // master nack ends the read, ack repeats the byte
          if (scl_rise) begin
            next_s.istate = sda ? PSL_I_IDLE : PSL_I_ACK;
            next_s.after_ack = PSL_I_RDATA;
          end
        end
        default: begin
          next_s.istate = PSL_I_IDLE;
          next_s.sda_drive = 1'b0;
        end
      endcase
    end

    // overvoltage hysteresis on the input rail
    // rising trip
    if (power_input_voltage_i >= rise_thr) begin
      next_s.ov_active = 1'b1;
    end else if (power_input_voltage_i < PSL_OV_FALL_MV) begin
      next_s.ov_active = 1'b0;
    end
    // set beats clear, so a persisting fault reappears at once
    // status flag set
    next_s.ov_flag = s.ov_active | (s.ov_flag & ~flag_clear);

    // sequencer; timer counts up and compares to live settings
    next_s.timer = s.timer + 32'h1;
    if (s.ov_active && s.seq != PSL_S_FAULT) begin
      next_s.seq = PSL_S_FAULT;
      next_s.sw_en = 1'b0;
      ramp_abort = 1'b1;
    end else begin
      unique case (s.seq)
        PSL_S_OFF: begin
          next_s.sw_en = 1'b0;
          next_s.timer = 32'h0;
          if (run && s.loaded) begin
            next_s.seq = PSL_S_TON;
          end
        end
        PSL_S_TON: begin
          if (!run) begin
            next_s.seq = PSL_S_OFF;
          end else if (s.timer + 32'h1 >= ton_cyc) begin
            next_s.seq = PSL_S_RISE;
            next_s.sw_en = 1'b1;
            ramp_start = 1'b1;
          end
        end
        PSL_S_RISE, PSL_S_ON: begin
          if (s.seq == PSL_S_RISE && ramp_done) begin
            next_s.seq = PSL_S_ON;
          end
          next_s.timer = 32'h0;
          if (!run) begin
            if (!s.soft_stop_en) begin
              next_s.seq = PSL_S_OFF;
              next_s.sw_en = 1'b0;
              ramp_abort = 1'b1;
            // zero wait goes straight to soft-stop
            end else if (toff_cyc == 32'h0) begin
              next_s.seq = PSL_S_FALL;
              ramp_start = 1'b1;
              ramp_down = 1'b1;
            end else begin
              next_s.seq = PSL_S_TOFF;
            end
          end
        end
        PSL_S_TOFF: begin
          if (!s.soft_stop_en) begin
            next_s.seq = PSL_S_OFF;
            next_s.sw_en = 1'b0;
            ramp_abort = 1'b1;
          end else if (s.timer + 32'h1 >= toff_cyc) begin
            next_s.seq = PSL_S_FALL;
            ramp_start = 1'b1;
            ramp_down = 1'b1;
          end
        end
        PSL_S_FALL: begin
          if (ramp_done || vout_sense_mv_i <= PSL_DISCHARGED_MV) begin
            next_s.seq = PSL_S_OFF;
            next_s.sw_en = 1'b0;
            ramp_abort = 1'b1;
          end
        end
        PSL_S_FAULT: begin
          // leave only once released and the rail is back down
          next_s.sw_en = 1'b0;
          ramp_abort = 1'b1;
          if (!run && !s.ov_active) begin
            next_s.seq = PSL_S_OFF;
          end
        end
        default: begin
          next_s.seq = PSL_S_OFF;
          next_s.sw_en = 1'b0;
          ramp_abort = 1'b1;
        end
      endcase
    end
  end

  // all state in one register
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
      s.istate <= PSL_I_IDLE;
      s.after_ack <= PSL_I_IDLE;
      s.seq <= PSL_S_OFF;
    end else begin
      s <= next_s;
    end
  end

  // open-drain data line: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = s.sda_drive;
  assign switch_enable_o = s.sw_en;
  assign reference_mv_o = ramp_ref;
endmodule : psl_seq
`default_nettype wire

// File: design/psl_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module psl_sync #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } psl_sync_t;

  psl_sync_t s;
  psl_sync_t next_s;

  // first stage feeds only the second
  always_comb begin
    next_s.meta = async_i;
    next_s.stable = s.meta;
  end

  // both stages clear on reset
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;
endmodule : psl_sync
`default_nettype wire

// File: test/psl_i2c_host.sv
// i2c host model for byte-command transfers
`timescale 1ns/1ps
`default_nettype none
module psl_i2c_host #(
  parameter logic [6:0] ADDR = 7'h24, // same arbitrary address as the core
  parameter int PH = 4 // clock phase in cycles, above the 2-flop sync delay
) (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_pull_o
);
  int nak_cnt = 0;
  // idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  task automatic ph();
    repeat (PH) @(posedge mclk_i);
    #1;
  endtask : ph
  // data moves only while clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_pull_o = ~b;
    ph();
    scl_o = 1'b1;
    ph();
    r = sda_i;
    scl_o = 1'b0;
    ph();
  endtask : bit_io
  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic r);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(1'b1, r);
    nak_cnt += int'(r);
  endtask : byte_io
  // start or repeated start
  task automatic start();
    sda_pull_o = 1'b0;
    ph();
    scl_o = 1'b1;
    ph();
    sda_pull_o = 1'b1;
    ph();
    scl_o = 1'b0;
    ph();
  endtask : start
  task automatic stop();
    sda_pull_o = 1'b1;
    ph();
    scl_o = 1'b1;
    ph();
    sda_pull_o = 1'b0;
    ph();
  endtask : stop
  // single-byte write, or send byte when full is low
  task automatic wr(input logic [7:0] cmd, input logic [7:0] data, input logic full = 1'b1);
    logic [7:0] rx;
    logic r;
    start();
    byte_io({ADDR, 1'b0}, rx, r);
    byte_io(cmd, rx, r);
    if (full) begin
      byte_io(data, rx, r);
    end
    stop();
  endtask : wr
  // single-byte read, closed by a not-acknowledge
  task automatic rd(input logic [7:0] cmd, output logic [7:0] data);
    logic [7:0] rx;
    logic r;
    start();
    byte_io({ADDR, 1'b0}, rx, r);
    byte_io(cmd, rx, r);
    start();
    byte_io({ADDR, 1'b1}, rx, r);
    byte_io(8'hff, data, r);
    nak_cnt--; // own closing nack
    stop();
  endtask : rd
endmodule : psl_i2c_host
`default_nettype wire

// File: test/psl_seq_asserts.sv
// port-level assertions for the power sequencing core
`timescale 1ns/1ps
`default_nettype none
module psl_seq_asserts
  import psl_pkg::*;
#(
  parameter int CYC_PER_US = PSL_CLK_MHZ
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic run_request_i,
  input wire logic [15:0] power_input_voltage_i,
  input wire logic [11:0] vout_target_mv_i,
  input wire logic sda_oe_o,
  input wire logic switch_enable_o,
  input wire logic [11:0] reference_mv_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  logic hot;
  logic [2:0] hot_cnt;
  int run_cnt;
  // sticky high-rail tracker and run age
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hot <= 1'b0;
      hot_cnt <= 3'h0;
      run_cnt <= 0;
    end else begin
      if (power_input_voltage_i >= PSL_OV_RISE_HI_MV) begin
        hot <= 1'b1;
      end else if (power_input_voltage_i < PSL_OV_FALL_MV) begin
        hot <= 1'b0;
      end
      hot_cnt <= !hot ? 3'h0 : (hot_cnt == 3'h7) ? hot_cnt : hot_cnt + 3'h1;
      run_cnt <= run_request_i ? run_cnt + 1 : 0;
    end
  end
  sequence over_rail;
    (power_input_voltage_i >= PSL_OV_RISE_HI_MV) [*3];
  endsequence
  sequence run_idle;
    (!run_request_i) [*4];
  endsequence
  // step checked in steady run on a safe rail
  property ramp_step;
    (switch_enable_o && $past(switch_enable_o) && run_cnt > 4
      && $past(power_input_voltage_i) < PSL_OV_RISE_LO_MV)
      |-> (reference_mv_o - $past(reference_mv_o)) <= 12'h001;
  endproperty
  a_ack_rise_scl: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data drive began with clock high");
  a_ack_fall_scl: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("data drive ended with clock high");
  a_ov_trip_fast: assert property (over_rail |=> !switch_enable_o)
    else $error("switching kept on a high rail");
  a_ov_latch_off: assert property (hot_cnt >= 3'h4 |-> !switch_enable_o)
    else $error("switching resumed before rail release");
  a_ton_min_wait: assert property ($rose(switch_enable_o) |-> run_cnt >= 500 * CYC_PER_US)
    else $error("switching began before the shortest wait");
  a_idle_no_start: assert property (run_idle |=> !$rose(switch_enable_o))
    else $error("switching began without a run request");
  a_ref_within: assert property (switch_enable_o |-> reference_mv_o <= vout_target_mv_i)
    else $error("reference above target");
  a_ref_step_up: assert property (ramp_step)
    else $error("reference not a steady rise");
endmodule : psl_seq_asserts
bind psl_seq psl_seq_asserts #(.CYC_PER_US(CYC_PER_US)) u_asserts (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl_i), .run_request_i(run_request_i),
  .power_input_voltage_i(power_input_voltage_i), .vout_target_mv_i(vout_target_mv_i),
  .sda_oe_o(sda_oe_o), .switch_enable_o(switch_enable_o), .reference_mv_o(reference_mv_o)
);
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the power sequencing core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psl_pkg::*;
  localparam int CPU = 1; // one cycle a microsecond keeps ramps short
  localparam logic [11:0] TGT = 12'd300;
  localparam logic [7:0] CMD [5] = '{PSL_CMD_OV_LIMIT, PSL_CMD_TON_WAIT, PSL_CMD_RISE,
    PSL_CMD_TOFF_WAIT, PSL_CMD_FALL};
  localparam logic [7:0] MSK [5] = '{8'h01, 8'h03, 8'h07, 8'h03, 8'h03};
  // strap flag, strap, soft-stop, fall, off wait, rise, on wait, ov select
  localparam logic [14:0] SETS [2] = '{{1'b0, 3'b010, 1'b1, 2'b11, 2'b01, 3'b101, 2'b10, 1'b1},
    {1'b1, 3'b110, 1'b0, 2'b00, 2'b10, 3'b011, 2'b01, 1'b0}};
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic run = 1'b0;
  logic [15:0] vin = 16'd12000;
  logic [14:0] nvm = 15'h0;
  logic scl;
  logic pull;
  logic sda_o;
  logic sda_oe;
  logic sw_en;
  logic [11:0] ref_mv;
  logic [7:0] rd;
  wire logic sda;
  int error_cnt = 0;
  int cmp_count = 0;
  int n;
  int e;
  // open-drain data line with pull-up
  assign sda = ~(pull | (sda_oe & ~sda_o));
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end
  // sensed output follows the reference
  psl_seq #(.CYC_PER_US(CPU)) u_dut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .run_request_i(run), .power_input_voltage_i(vin),
    .vout_sense_mv_i(ref_mv), .vout_target_mv_i(TGT), .vid_control_i(1'b1),
    .input_ov_select_nvm_i(nvm[0]), .ton_wait_nvm_i(nvm[2:1]), .rise_nvm_i(nvm[5:3]),
    .rise_strap_i(nvm[13:11]), .rise_from_strap_i(nvm[14]), .toff_wait_nvm_i(nvm[7:6]),
    .fall_nvm_i(nvm[9:8]), .soft_stop_en_nvm_i(nvm[10]), .switch_enable_o(sw_en),
    .reference_mv_o(ref_mv)
  );
  psl_i2c_host u_host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : tick
  // bounded wait: 0 switching on, 1 switching off, 2 reference at target
  task automatic await(input logic [1:0] k);
    n = 0;
    while (n < 40000 && !(k == 2'd0 ? sw_en === 1'b1 : k == 2'd1 ? sw_en === 1'b0
        : ref_mv === TGT)) begin
      tick(1);
      n++;
    end
  endtask : await
  function automatic logic [15:0] inr(input int v, input int lo, input int hi);
    return 16'(v >= lo && v <= hi);
  endfunction : inr
  function automatic logic [7:0] nv_exp(input int i, input logic [14:0] v);
    case (i)
      0: return {7'h0, v[0]};
      1: return {6'h0, v[2:1]};
      2: return {5'h0, v[14] ? v[13:11] : v[5:3]};
      3: return {6'h0, v[7:6]};
      default: return {6'h0, v[9:8]};
    endcase
  endfunction : nv_exp
  initial begin
    // load from nvm or strap; the second pass takes the rise setting from the strap
    foreach (SETS[s]) begin
      nvm = SETS[s];
      reset_n_i = 1'b0;
      tick(8);
      reset_n_i = 1'b1;
      tick(4);
      for (int i = 0; i < 5; i++) begin
        u_host.rd(CMD[i], rd);
        chk(rd, nv_exp(i, SETS[s])); // loaded value
      end
    end
    // writes keep field bits only; unmapped reads zero
    for (int i = 0; i < 5; i++) begin
      u_host.wr(CMD[i], 8'hff);
      u_host.rd(CMD[i], rd);
      chk(rd, MSK[i]); // field mask
    end
    u_host.wr(8'h10, 8'hff);
    u_host.rd(8'h10, rd);
    chk(rd, 8'h00); // unmapped read
    // every on-wait code and every ramp time, then hard stop
    for (int i = 0; i < 5; i++) begin
      u_host.wr(PSL_CMD_TON_WAIT, 8'(i % 4));
      u_host.wr(PSL_CMD_RISE, (i == 4) ? 8'h07 : 8'(i));
      run = 1'b1;
      await(2'd0);
      e = 500 * (i % 4 + 1) * CPU;
      chk(inr(n, e, e + 6), 16'h1); // on wait
      await(2'd2);
      e = (1000 << i) * CPU;
      chk(inr(n, e - 4, e + 4), 16'h1); // ramp time
      run = 1'b0;
      tick(6);
      chk(sw_en, 1'b0); // immediate off
      chk(ref_mv, 12'h000); // reference cleared
    end
    // soft-stop: off wait, fall to 200 mV
    u_host.wr(PSL_CMD_SETUP1, 8'h01);
    u_host.wr(PSL_CMD_RISE, 8'h00);
    for (int t = 1; t < 4; t += 2) begin
      u_host.wr(PSL_CMD_TOFF_WAIT, 8'(t));
      u_host.wr(PSL_CMD_FALL, 8'(t));
      run = 1'b1;
      await(2'd2);
      run = 1'b0;
      await(2'd1);
      e = (500 * (t + 1) + (500 << t) / 3) * CPU;
      chk(inr(n, e, e + 8), 16'h1); // stop time
    end
    // low trip, latch-off, sticky flag, release, flush
    u_host.wr(PSL_CMD_OV_LIMIT, 8'h00);
    run = 1'b1;
    await(2'd0);
    vin = 16'd17000;
    tick(6);
    chk(sw_en, 1'b0); // trip at low level
    vin = 16'd14000;
    u_host.rd(PSL_CMD_STATUS_IN, rd);
    chk(rd, 8'h80); // flag set
    u_host.wr(PSL_CMD_STATUS_IN, 8'h80);
    u_host.rd(PSL_CMD_STATUS_IN, rd);
    chk(rd, 8'h80); // fault persists
    vin = 16'd13000;
    u_host.wr(PSL_CMD_FLUSH, 8'h00, 1'b0);
    u_host.rd(PSL_CMD_STATUS_IN, rd);
    chk(rd, 8'h00); // flush clears
    chk(sw_en, 1'b0); // still latched off
    run = 1'b0;
    tick(6);
    // high trip level ignores 17 V
    u_host.wr(PSL_CMD_OV_LIMIT, 8'h01);
    run = 1'b1;
    await(2'd0);
    vin = 16'd17000;
    tick(6);
    chk(sw_en, 1'b1); // below high level
    vin = 16'd18600;
    tick(6);
    chk(sw_en, 1'b0); // trip at high level
    run = 1'b0;
    vin = 16'd12000;
    chk(16'(u_host.nak_cnt), 16'h0); // all bytes acknowledged
    report_and_stop();
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge mclk_i);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
